// [verilog/gtc_pkg.sv]
// Package of constants and state type for the gated 16-bit timer counter
`default_nettype none
package gtc_pkg;
  localparam logic [4:0] OFS_CNT_LO = 5'h00;
  localparam logic [4:0] OFS_CNT_HI = 5'h04;
  localparam logic [4:0] OFS_CTL = 5'h08;
  localparam logic [4:0] OFS_CMP_CTL = 5'h0C;
  localparam logic [4:0] OFS_FLAG = 5'h10;
  localparam logic [4:0] OFS_PIE = 5'h14;
  localparam logic [4:0] OFS_INTCTL = 5'h18;
  localparam int CTL_ON = 0;
  localparam int CTL_CS = 1;
  localparam int CTL_SYNC = 2;
  localparam int CTL_OSCEN = 3;
  localparam int CTL_PS_LO = 4;
  localparam int CTL_GE = 6;
  localparam int CTL_POL = 7;
  localparam int GSS_BIT = 1;
  localparam int FLAG_BIT = 0;
  localparam int IE_BIT = 0;
  localparam int PERIPHERAL_INT_ENABLE_BIT = 6;
  localparam int GIE_BIT = 7;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic GSS_RST = 1'b1;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  typedef struct packed {
    logic [15:0] cnt;
    logic [2:0] ps;
    logic [1:0] div;
    logic s1;
    logic s2;
    logic prev;
    logic armed;
    logic [7:0] ctl;
    logic gss;
    logic flag;
    logic ie;
    logic peripheral_int_enable;
    logic global_int_enable;
    logic [31:0] rdata;
    logic rd_ack;
  } gtc_st_t;
endpackage : gtc_pkg
`default_nettype wire

// [verilog/gtc_timer.sv]
// Gated 16-bit timer counter with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module gtc_timer (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Avalon-MM slave
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Count sources and gate
  input wire logic external_count_input_i,
  input wire logic lp_osc_clk_i,
  input wire logic int_osc_no_clock_output_pin_i,
  input wire logic gate_input_pin_i,
  input wire logic comparator_output_i,
  input wire logic special_event_i,
  input wire logic sleep_i,
  // Status
  output logic lp_osc_active_o,
  output logic irq_o,
  output logic wake_o
);
  gtc_pkg::gtc_st_t s;
  gtc_pkg::gtc_st_t n;

  logic wr;
  logic wr_lo;
  logic wr_hi;
  logic wr_cnt;
  logic async_mode;
  logic ext_lvl;
  logic src_lvl;
  logic ext_rise;
  logic ext_fall;
  logic instr_tick;
  logic src_tick;
  logic gate_sig;
  logic gate_act;
  logic run;
  logic [1:0] psel;
  logic [2:0] ps_lim;
  logic ps_done;
  logic inc;
  logic rollover;
  logic clr_flag;

  assign wr = write_i & byteenable_i[0];
  assign wr_lo = wr & (address_i == gtc_pkg::OFS_CNT_LO);
  assign wr_hi = wr & (address_i == gtc_pkg::OFS_CNT_HI);
  assign wr_cnt = wr_lo | wr_hi;

  // Crystal feeds the timer only in oscillator-only mode
  assign lp_osc_active_o = s.ctl[gtc_pkg::CTL_OSCEN] & int_osc_no_clock_output_pin_i;
  assign ext_lvl = lp_osc_active_o ? lp_osc_clk_i : external_count_input_i;
  assign async_mode = s.ctl[gtc_pkg::CTL_CS] & s.ctl[gtc_pkg::CTL_SYNC];
  // Bypass skips the two-stage synchroniser; the edge history is shared,
  // so a mode switch can drop or add a single count
  assign src_lvl = async_mode ? ext_lvl : s.s2;
  assign ext_rise = src_lvl & ~s.prev;
  assign ext_fall = ~src_lvl & s.prev;
  assign instr_tick = (s.div == gtc_pkg::INSTR_DIV_LAST);
  // External edges count only once armed by a falling edge
  assign src_tick = s.ctl[gtc_pkg::CTL_CS] ? (ext_rise & s.armed) : instr_tick;

  assign gate_sig = s.gss ? comparator_output_i : gate_input_pin_i;
  assign gate_act = s.ctl[gtc_pkg::CTL_POL] ? gate_sig : ~gate_sig;
  // Sleep freezes all but the asynchronous counter
  assign run = s.ctl[gtc_pkg::CTL_ON]
             & (~s.ctl[gtc_pkg::CTL_GE] | gate_act)
             & (~sleep_i | async_mode);

  assign psel = s.ctl[gtc_pkg::CTL_PS_LO +: 2];
  assign ps_lim = {psel == 2'h3, psel[1], psel != 2'h0};
  assign ps_done = (s.ps == ps_lim);
  assign inc = run & src_tick & ps_done;
  // A special event clear swallows the wrap, so no flag
  assign rollover = inc & (s.cnt == gtc_pkg::CNT_MAX)
                  & ~(special_event_i & ~wr_cnt);
  assign clr_flag = wr & (address_i == gtc_pkg::OFS_FLAG)
                  & ~writedata_i[gtc_pkg::FLAG_BIT];

  always_comb
  begin
    n = s;
    n.div = s.div + 2'h1;
    n.s1 = ext_lvl;
    n.s2 = s.s1;
    n.prev = src_lvl;
    if (!s.ctl[gtc_pkg::CTL_CS])
    begin
      n.armed = 1'b0;
    end
    else if (ext_fall)
    begin
      n.armed = 1'b1;
    end
    if (wr_cnt)
    begin
      n.ps = 3'h0;
    end
    else if (run && src_tick)
    begin
      n.ps = ps_done ? 3'h0 : s.ps + 3'h1;
    end
    if (inc)
    begin
      n.cnt = s.cnt + 16'h0001;
    end
    if (special_event_i && !wr_cnt)
    begin
      n.cnt = 16'h0000;
    end
    if (wr_lo)
    begin
      n.cnt[7:0] = writedata_i[7:0];
    end
    if (wr_hi)
    begin
      n.cnt[15:8] = writedata_i[7:0];
    end
    if (wr && address_i == gtc_pkg::OFS_CTL)
    begin
      n.ctl = writedata_i[7:0];
    end
    if (wr && address_i == gtc_pkg::OFS_CMP_CTL)
    begin
      n.gss = writedata_i[gtc_pkg::GSS_BIT];
    end
    if (wr && address_i == gtc_pkg::OFS_PIE)
    begin
      n.ie = writedata_i[gtc_pkg::IE_BIT];
    end
    if (wr && address_i == gtc_pkg::OFS_INTCTL)
    begin
      n.peripheral_int_enable = writedata_i[gtc_pkg::PERIPHERAL_INT_ENABLE_BIT];
      n.global_int_enable = writedata_i[gtc_pkg::GIE_BIT];
    end
    // Software may also set the flag; a rollover beats a clear
    if (wr && address_i == gtc_pkg::OFS_FLAG)
    begin
      n.flag = writedata_i[gtc_pkg::FLAG_BIT];
    end
    if (rollover)
    begin
      n.flag = 1'b1;
    end
    n.rd_ack = read_i & ~s.rd_ack;
    // Read data is captured from the one clock domain, so bytes are whole
    if (read_i && !s.rd_ack)
    begin
      n.rdata = 32'h0000_0000;
      unique case (address_i)
        gtc_pkg::OFS_CNT_LO: n.rdata[7:0] = s.cnt[7:0];
        gtc_pkg::OFS_CNT_HI: n.rdata[7:0] = s.cnt[15:8];
        gtc_pkg::OFS_CTL: n.rdata[7:0] = s.ctl;
        gtc_pkg::OFS_CMP_CTL: n.rdata[gtc_pkg::GSS_BIT] = s.gss;
        gtc_pkg::OFS_FLAG: n.rdata[gtc_pkg::FLAG_BIT] = s.flag;
        gtc_pkg::OFS_PIE: n.rdata[gtc_pkg::IE_BIT] = s.ie;
        gtc_pkg::OFS_INTCTL:
        begin
          n.rdata[gtc_pkg::PERIPHERAL_INT_ENABLE_BIT] = s.peripheral_int_enable;
          n.rdata[gtc_pkg::GIE_BIT] = s.global_int_enable;
        end
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s <= '0;
      s.ctl <= gtc_pkg::CTL_RST;
      s.gss <= gtc_pkg::GSS_RST;
    end
    else
    begin
      s <= n;
    end
  end

  // One wait state on reads, none on writes
  assign waitrequest_o = read_i & ~s.rd_ack;
  assign readdata_o = s.rdata;
  assign irq_o = s.flag & s.ie & s.peripheral_int_enable & s.global_int_enable;
  // Wake ignores the global enable; the vector then depends on irq_o
  assign wake_o = sleep_i & s.ctl[gtc_pkg::CTL_ON] & s.flag & s.ie & s.peripheral_int_enable;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_rollover;
    inc && s.cnt == 16'hFFFF && !special_event_i;
  endsequence
  sequence s_wrapped;
    s.cnt == 16'h0000 && s.flag;
  endsequence

  chk_byte_write: assert property (
    wr_lo && !wr_hi |=> s.cnt[7:0] == $past(writedata_i[7:0])
      && s.cnt[15:8] == $past(s.cnt[15:8]))
    else $error("Low byte write corrupted the count");

  chk_rollover_flag: assert property (
    s_rollover and !wr_cnt |=> s_wrapped)
    else $error("Rollover did not wrap and set the flag");

  chk_event_clear: assert property (
    special_event_i && !wr_cnt && !s.flag && !(wr && address_i == gtc_pkg::OFS_FLAG)
      |=> s.cnt == 16'h0000 && !s.flag)
    else $error("Special event did not clear the count cleanly");

  chk_write_wins: assert property (
    special_event_i && wr_hi && !wr_lo |=> s.cnt[15:8] == $past(writedata_i[7:0])
      && s.cnt[7:0] == $past(s.cnt[7:0]) + {7'h00, $past(inc)})
    else $error("Special event overrode a byte write");

  chk_ps_cleared: assert property (
    wr_cnt |=> s.ps == 3'h0)
    else $error("Prescaler not cleared by count write");

  chk_off_holds: assert property (
    !s.ctl[gtc_pkg::CTL_ON] && !wr_cnt && !special_event_i |=> $stable(s.cnt))
    else $error("Stopped timer changed its count");

  chk_arm_first: assert property (
    s.ctl[gtc_pkg::CTL_CS] && !s.armed |-> !inc)
    else $error("Count before first falling edge");

  chk_sleep_freeze: assert property (
    sleep_i && !async_mode |-> !inc)
    else $error("Synchronous counter advanced in sleep");

  chk_flag_sticky: assert property (
    s.flag && !clr_flag |=> s.flag)
    else $error("Overflow flag dropped without a clear");

  chk_irq_cause: assert property (
    $rose(irq_o) |-> s.flag && s.ie && s.peripheral_int_enable && s.global_int_enable)
    else $error("Interrupt raised without all enables");

  chk_gate_block: assert property (
    s.ctl[gtc_pkg::CTL_GE] && !gate_act |-> !inc)
    else $error("Count while gate inactive");

  chk_read_wait: assert property (
    read_i && !s.rd_ack |=> !waitrequest_o || !read_i)
    else $error("Read answer exceeded one wait state");

  sequence s_read_take;
    read_i && !s.rd_ack;
  endsequence
  sequence s_count_step;
    inc && !wr_cnt && !special_event_i;
  endsequence

  chk_hi_write: assert property (
    wr_hi && !wr_lo |=> s.cnt[15:8] == $past(writedata_i[7:0])
      && s.cnt[7:0] == $past(s.cnt[7:0]) + {7'h00, $past(inc)})
    else $error("High byte write corrupted the count");

  chk_count_step: assert property (
    s_count_step |=> s.cnt == $past(s.cnt) + 16'h0001)
    else $error("Count did not advance by one");

  chk_count_hold: assert property (
    !inc && !wr_cnt && !special_event_i |=> $stable(s.cnt))
    else $error("Count moved without an increment");

  chk_src_instr: assert property (
    !s.ctl[gtc_pkg::CTL_CS] && inc |-> instr_tick)
    else $error("Internal source counted off its tick");

  chk_src_ext: assert property (
    s.ctl[gtc_pkg::CTL_CS] && inc |-> ext_rise)
    else $error("External source counted without a rising edge");

  chk_arm_set: assert property (
    s.ctl[gtc_pkg::CTL_CS] && ext_fall |=> s.armed)
    else $error("Falling edge did not arm the counter");

  chk_arm_clear: assert property (
    !s.ctl[gtc_pkg::CTL_CS] |=> !s.armed)
    else $error("Arming kept while on internal source");

  chk_ps_step: assert property (
    run && src_tick && !ps_done && !wr_cnt |=> s.ps == $past(s.ps) + 3'h1)
    else $error("Prescaler did not step on a tick");

  chk_ps_wrap: assert property (
    inc && !wr_cnt |=> s.ps == 3'h0)
    else $error("Prescaler did not restart after a count");

  chk_ps_hold: assert property (
    !(run && src_tick) && !wr_cnt |=> $stable(s.ps))
    else $error("Prescaler moved without a tick");

  chk_osc_ignored: assert property (
    !int_osc_no_clock_output_pin_i |-> !lp_osc_active_o)
    else $error("Crystal enabled outside oscillator-only mode");

  // Outside the asynchronous bypass, two flops of delay keep a changing pin from reaching the edge logic
  chk_sync_stages: assert property (
    $past(nrst_i) && $past(nrst_i, 2) |-> s.s2 == $past(ext_lvl, 2))
    else $error("Synchroniser delay is not two clocks");

  chk_edge_history: assert property (
    $past(nrst_i) |-> s.prev == $past(src_lvl))
    else $error("Edge history lost a sample");

  chk_free_run: assert property (
    s.ctl[gtc_pkg::CTL_ON] && !s.ctl[gtc_pkg::CTL_GE] && !sleep_i
      && src_tick && ps_done |-> inc)
    else $error("Ungated timer missed a count");

  chk_gate_pass: assert property (
    s.ctl[gtc_pkg::CTL_ON] && s.ctl[gtc_pkg::CTL_GE] && gate_act && !sleep_i
      && src_tick && ps_done |-> inc)
    else $error("Open gate blocked a count");

  chk_gate_high: assert property (
    s.ctl[gtc_pkg::CTL_GE] && s.ctl[gtc_pkg::CTL_POL] && !gate_sig |-> !inc)
    else $error("High gate counted while gate low");

  chk_gate_low: assert property (
    s.ctl[gtc_pkg::CTL_GE] && !s.ctl[gtc_pkg::CTL_POL] && gate_sig |-> !inc)
    else $error("Low gate counted while gate high");

  chk_gate_pin: assert property (
    !s.gss |-> gate_sig == gate_input_pin_i)
    else $error("Gate not taken from the pin");

  chk_gate_cmp: assert property (
    s.gss |-> gate_sig == comparator_output_i)
    else $error("Gate not taken from the comparator");

  chk_flag_set: assert property (
    rollover |=> s.flag)
    else $error("Rollover left the flag clear");

  chk_irq_enables: assert property (
    !s.global_int_enable || !s.peripheral_int_enable || !s.ie |-> !irq_o)
    else $error("Interrupt with an enable clear");

  chk_sleep_async: assert property (
    sleep_i && async_mode && s.ctl[gtc_pkg::CTL_ON] && !s.ctl[gtc_pkg::CTL_GE]
      && src_tick && ps_done |-> inc)
    else $error("Asynchronous counter stalled in sleep");

  chk_wake_on: assert property (
    !s.ctl[gtc_pkg::CTL_ON] || !sleep_i |-> !wake_o)
    else $error("Wake while timer off or awake");

  chk_wake_enables: assert property (
    wake_o |-> s.flag && s.ie && s.peripheral_int_enable)
    else $error("Wake without flag and enables");

  chk_read_lo: assert property (
    s_read_take ##0 (address_i == gtc_pkg::OFS_CNT_LO)
      |=> readdata_o[7:0] == $past(s.cnt[7:0]))
    else $error("Low byte read returned a torn value");

  chk_read_hi: assert property (
    s_read_take ##0 (address_i == gtc_pkg::OFS_CNT_HI)
      |=> readdata_o[7:0] == $past(s.cnt[15:8]))
    else $error("High byte read returned a torn value");

  chk_read_upper: assert property (
    s_read_take |=> readdata_o[31:8] == 24'h00_0000)
    else $error("Read data upper bits not zero");

  // Writes land at the request edge, so a master never stalls on them
  chk_write_nowait: assert property (
    write_i |-> !waitrequest_o)
    else $error("Write was made to wait");

endmodule : gtc_timer
`default_nettype wire

// [tb/gtc_far_side.sv]
// Far-side model: external count clock, gate pin and comparator output
`timescale 1ns/1ps
`default_nettype none
module gtc_far_side (
  // Bench control
  input wire logic core_clk_i,
  input wire logic run_i,
  input wire logic gate_lvl_i,
  input wire logic cmp_lvl_i,
  // Lines into the timer
  output logic ext_clk_o,
  output logic gate_pin_o,
  output logic cmp_out_o
);
  logic [1:0] ph_r = 2'h0;
  logic lvl_r = 1'b0;
  // Count clock stands still between bursts; even bursts end low
  always @(posedge core_clk_i)
  begin
    ph_r <= run_i ? ph_r + 2'h1 : 2'h0;
    if (run_i && ph_r == 2'h3)
      lvl_r <= ~lvl_r;
  end
  assign ext_clk_o = lvl_r;
  assign gate_pin_o = gate_lvl_i;
  assign cmp_out_o = cmp_lvl_i;
endmodule : gtc_far_side
`default_nettype wire

// [tb/tb_gated_16bit_timer_counter.sv]
// Self-checking bench for the gated 16-bit timer counter
`timescale 1ns/1ps
`default_nettype none
module tb_gated_16bit_timer_counter;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [31:0] got;
  logic wreq, ext, gpin, comparator_output, lp_act, irq, wake;
  logic osc = 1'b0, sev = 1'b0, slp = 1'b0, run = 1'b0, gl = 1'b0, cl = 1'b0;
  int fails = 0;
  int checked = 0;
  always #25 clk = ~clk;
  gtc_timer dut (.core_clk_i(clk), .nrst_i(nrst), .address_i(addr), .read_i(rd),
    .write_i(wr), .writedata_i(wdata), .byteenable_i(4'hF), .readdata_o(rdata),
    .waitrequest_o(wreq), .external_count_input_i(ext), .lp_osc_clk_i(1'b0),
    .int_osc_no_clock_output_pin_i(osc), .gate_input_pin_i(gpin), .comparator_output_i(comparator_output),
    .special_event_i(sev), .sleep_i(slp), .lp_osc_active_o(lp_act), .irq_o(irq),
    .wake_o(wake));
  gtc_far_side far (.core_clk_i(clk), .run_i(run), .gate_lvl_i(gl), .cmp_lvl_i(cl),
    .ext_clk_o(ext), .gate_pin_o(gpin), .cmp_out_o(comparator_output));

  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= {24'h00_0000, d};
    wr <= w;
    rd <= ~w;
    do
      @(posedge clk);
    while (wreq !== 1'b0);
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic cmp(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      fails++;
      $display("unexpected at %0t: got %h, want %h to %h", $time, g, lo, hi);
    end
  endtask : cmp

  task automatic rchk(input logic [4:0] a, input logic [31:0] lo, input logic [31:0] hi);
    bus(1'b0, a, 8'h00);
    cmp(got, lo, hi);
  endtask : rchk

  // Timer is always stopped here, so no write races an increment
  task automatic wcnt(input logic [7:0] h, input logic [7:0] l);
    bus(1'b1, gtc_pkg::OFS_CNT_HI, h);
    bus(1'b1, gtc_pkg::OFS_CNT_LO, l);
  endtask : wcnt

  task automatic run_case(input logic [7:0] g, input logic [7:0] c, input logic p,
    input logic q, input int n, input logic [31:0] lo, input logic [31:0] hi);
    wcnt(8'h00, 8'h00);
    bus(1'b1, gtc_pkg::OFS_CMP_CTL, g);
    gl <= p;
    cl <= q;
    bus(1'b1, gtc_pkg::OFS_CTL, c);
    repeat (n) @(posedge clk);
    bus(1'b1, gtc_pkg::OFS_CTL, 8'h00);
    rchk(gtc_pkg::OFS_CNT_LO, lo, hi);
  endtask : run_case

  task automatic ext_run(input logic [7:0] c, input logic s);
    slp <= s;
    bus(1'b1, gtc_pkg::OFS_CTL, c);
    run <= 1'b1;
    repeat (24) @(posedge clk);
    run <= 1'b0;
    repeat (6) @(posedge clk);
    slp <= 1'b0;
  endtask : ext_run

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rchk(gtc_pkg::OFS_CTL, 8'h00, 8'h00);
    rchk(gtc_pkg::OFS_CMP_CTL, 8'h02, 8'h02);
    rchk(5'h1C, 8'h00, 8'h00);
    wcnt(8'h12, 8'h34);
    bus(1'b1, gtc_pkg::OFS_CNT_LO, 8'h56);
    rchk(gtc_pkg::OFS_CNT_HI, 8'h12, 8'h12);
    rchk(gtc_pkg::OFS_CNT_LO, 8'h56, 8'h56);
    for (int i = 0; i < 4; i++)
      run_case(8'h02, {2'b00, i[1:0], 4'h1}, 1'b0, 1'b0, 32 << i, 8'h07, 8'h09);
    run_case(8'h02, 8'hC1, 1'b1, 1'b0, 40, 8'h00, 8'h00);
    run_case(8'h02, 8'hC1, 1'b0, 1'b1, 40, 8'h09, 8'h0B);
    run_case(8'h00, 8'hC1, 1'b1, 1'b0, 40, 8'h09, 8'h0B);
    run_case(8'h00, 8'h41, 1'b1, 1'b1, 40, 8'h00, 8'h00);
    run_case(8'h00, 8'h40, 1'b0, 1'b0, 40, 8'h00, 8'h00);
    wcnt(8'hFF, 8'hFE);
    bus(1'b1, gtc_pkg::OFS_CTL, 8'h01);
    repeat (12) @(posedge clk);
    bus(1'b1, gtc_pkg::OFS_CTL, 8'h00);
    rchk(gtc_pkg::OFS_FLAG, 8'h01, 8'h01);
    rchk(gtc_pkg::OFS_CNT_HI, 8'h00, 8'h00);
    cmp({31'h0, irq}, 8'h00, 8'h00);
    bus(1'b1, gtc_pkg::OFS_PIE, 8'h01);
    bus(1'b1, gtc_pkg::OFS_INTCTL, 8'h40);
    slp <= 1'b1;
    bus(1'b1, gtc_pkg::OFS_CTL, 8'h01);
    repeat (4) @(posedge clk);
    cmp({31'h0, wake}, 8'h01, 8'h01);
    cmp({31'h0, irq}, 8'h00, 8'h00);
    bus(1'b1, gtc_pkg::OFS_INTCTL, 8'hC0);
    @(posedge clk);
    cmp({31'h0, irq}, 8'h01, 8'h01);
    slp <= 1'b0;
    bus(1'b1, gtc_pkg::OFS_CTL, 8'h00);
    bus(1'b1, gtc_pkg::OFS_FLAG, 8'h00);
    rchk(gtc_pkg::OFS_FLAG, 8'h00, 8'h00);
    cmp({31'h0, irq}, 8'h00, 8'h00);
    wcnt(8'h12, 8'h55);
    sev <= 1'b1;
    @(posedge clk);
    sev <= 1'b0;
    rchk(gtc_pkg::OFS_CNT_HI, 8'h00, 8'h00);
    rchk(gtc_pkg::OFS_FLAG, 8'h00, 8'h00);
    bus(1'b1, gtc_pkg::OFS_CNT_HI, 8'h12);
    @(posedge clk);
    sev <= 1'b1;
    addr <= gtc_pkg::OFS_CNT_LO;
    wdata <= 32'h0000_0077;
    wr <= 1'b1;
    @(posedge clk);
    sev <= 1'b0;
    wr <= 1'b0;
    rchk(gtc_pkg::OFS_CNT_LO, 8'h77, 8'h77);
    rchk(gtc_pkg::OFS_CNT_HI, 8'h12, 8'h12);
    wcnt(8'h00, 8'h00);
    ext_run(8'h03, 1'b0);
    rchk(gtc_pkg::OFS_CNT_LO, 8'h02, 8'h02);
    ext_run(8'h03, 1'b1);
    rchk(gtc_pkg::OFS_CNT_LO, 8'h02, 8'h02);
    ext_run(8'h07, 1'b1);
    rchk(gtc_pkg::OFS_CNT_LO, 8'h05, 8'h05);
    bus(1'b1, gtc_pkg::OFS_CTL, 8'h08);
    @(posedge clk);
    cmp({31'h0, lp_act}, 8'h00, 8'h00);
    osc <= 1'b1;
    @(posedge clk);
    cmp({31'h0, lp_act}, 8'h01, 8'h01);
    ext_run(8'h0B, 1'b0);
    rchk(gtc_pkg::OFS_CNT_LO, 8'h05, 8'h05);
    print_verdict();
  end
endmodule : tb_gated_16bit_timer_counter
`default_nettype wire
